// ===== rtl/pbc_pkg.sv
// Shared constants, layouts and helpers for the polled bit-check receiver.
package pbc_pkg;

  // Base tick of all polling timing, derived from the system clock.
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned TCLK_NS = 2066;
  localparam int unsigned TICK_CYC = TCLK_NS / CLK_NS;
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1);

  // Register byte addresses.
  localparam logic [7:0] ADDR_OPERATING_CONFIG_REGISTER = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing figures in base ticks or extended ticks.
  localparam logic [17:0] T_STARTUP_TICKS = 18'h00080;
  localparam logic [17:0] T_SYNC_TICKS = 18'h00004;
  localparam logic [7:0] T_FORCE_DLY_TICKS = 8'h08;
  localparam logic [7:0] T_HOLD_MIN_TICKS = 8'h04;
  localparam logic [7:0] T_REL_DLY_TICKS = 8'h08;
  localparam logic [9:0] T_OFF_MIN_TICKS = 10'h020;
  localparam logic [9:0] T_OFF_MAX_TICKS = 10'h200;
  localparam logic [7:0] T_DATA_MIN_X = 8'h06;
  localparam logic [7:0] T_DATA_LMAX_X = 8'h60;

  localparam logic [4:0] SLEEP_FOREVER = 5'h1F;
  localparam logic [3:0] SLEEP_XMULT = 4'h8;
  localparam logic [4:0] CHECKS_PER_STEP = 5'h06;

  // Operating configuration word, most significant field first.
  typedef struct packed {
    logic noise_dis;
    logic xsleep;
    logic [4:0] sleep;
    logic ask_fsk;
    logic [1:0] nbit;
    logic [1:0] rate_range_select;
  } pbc_operating_config_register_t;

  typedef struct packed {
    logic [5:0] lim_max;
    logic [5:0] lim_min;
  } pbc_limit_t;

  localparam pbc_operating_config_register_t OPERATING_CONFIG_REGISTER_RST = 12'h8C4;
  localparam pbc_limit_t LIMIT_RST = 12'h60E;

  typedef enum logic [2:0] {
    MD_SLEEP,
    MD_STARTUP,
    MD_CHECK,
    MD_RECV,
    MD_SYNC
  } pbc_mode_t;

  typedef struct packed {
    logic clk_run;
    logic rechk;
    pbc_mode_t mode;
  } pbc_status_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } pbc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } pbc_axi_rsp_t;

  // Last divider state of the extended tick for a rate range.
  function automatic logic [2:0] pbc_xlast(input logic [1:0] rr);
    case (rr)
      2'h0: pbc_xlast = 3'h7;
      2'h1: pbc_xlast = 3'h3;
      2'h2: pbc_xlast = 3'h1;
      default: pbc_xlast = 3'h0;
    endcase
  endfunction

  function automatic logic [4:0] pbc_need(input logic [1:0] nb);
    pbc_need = 5'(CHECKS_PER_STEP * 5'(nb));
  endfunction

  function automatic logic [7:0] pbc_diff(input pbc_limit_t l);
    pbc_diff = (l.lim_max >= l.lim_min) ? 8'(l.lim_max - l.lim_min) : 8'h00;
  endfunction

  function automatic logic [7:0] pbc_dbl_lo(input pbc_limit_t l);
    pbc_dbl_lo = 8'(8'(l.lim_min) + 8'(l.lim_max) - (pbc_diff(l) >> 1));
  endfunction

  function automatic logic [7:0] pbc_dbl_hi(input pbc_limit_t l);
    pbc_dbl_hi = 8'(8'(l.lim_min) + 8'(l.lim_max)
      + ((pbc_diff(l) + 8'h01) >> 1));
  endfunction

endpackage

// ===== rtl/pbc_receiver.sv
// Polled bit-check receiver back end with AXI4-Lite configuration.

`timescale 1ns/1ps
`default_nettype none

module pbc_receiver #(
  parameter int unsigned SLEEP_UNIT = 1024
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Register bus
  input wire pbc_pkg::pbc_axi_req_t axi_req_in,
  output var pbc_pkg::pbc_axi_rsp_t axi_rsp_out,
  // Demodulator and host pins
  input wire logic dem_in,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe_n_out,
  input wire logic force_n_in,
  output logic data_clk_out,
  output logic active_indicator_out
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        merge[8*i +: 8] = wd[8*i +: 8];
      end
    end
  endfunction

  // Synchronisers.
  logic [2:0] dem_sy_ff, nxt_dem_sy;
  logic [2:0] dat_sy_ff, nxt_dat_sy;
  logic [2:0] frc_sy_ff, nxt_frc_sy;
  logic dem_st_ff, nxt_dem_st;
  logic dat_st_ff, nxt_dat_st;
  logic frc_st_ff, nxt_frc_st;

  always_comb begin
    nxt_dem_sy = {dem_sy_ff[1:0], dem_in};
    nxt_dat_sy = {dat_sy_ff[1:0], data_pin_in};
    nxt_frc_sy = {frc_sy_ff[1:0], force_n_in};
    nxt_dem_st = (dem_sy_ff[1] == dem_sy_ff[2]) ? dem_sy_ff[2] : dem_st_ff;
    nxt_dat_st = (dat_sy_ff[1] == dat_sy_ff[2]) ? dat_sy_ff[2] : dat_st_ff;
    nxt_frc_st = (frc_sy_ff[1] == frc_sy_ff[2]) ? frc_sy_ff[2] : frc_st_ff;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dem_sy_ff <= 3'h7;
      dat_sy_ff <= 3'h7;
      frc_sy_ff <= 3'h7;
      dem_st_ff <= 1'b1;
      dat_st_ff <= 1'b1;
      frc_st_ff <= 1'b1;
    end else begin
      dem_sy_ff <= nxt_dem_sy;
      dat_sy_ff <= nxt_dat_sy;
      frc_sy_ff <= nxt_frc_sy;
      dem_st_ff <= nxt_dem_st;
      dat_st_ff <= nxt_dat_st;
      frc_st_ff <= nxt_frc_st;
    end
  end

  // Register bus.
  pbc_pkg::pbc_operating_config_register_t opm_ff, nxt_opm;
  pbc_pkg::pbc_limit_t lim_ff, nxt_lim;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic cfg_rst;
  logic wr_go;
  logic [7:0] wa;
  logic [7:0] ra;
  pbc_pkg::pbc_status_t stat;

  always_comb begin
    nxt_opm = opm_ff;
    nxt_lim = lim_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    wa = {axi_req_in.awaddr[7:2], 2'h0};
    ra = {axi_req_in.araddr[7:2], 2'h0};
    wr_go = axi_req_in.awvalid && axi_req_in.wvalid && !bvalid_ff;
    if (bvalid_ff && axi_req_in.bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = pbc_pkg::RESP_OKAY;
      case (wa)
        pbc_pkg::ADDR_OPERATING_CONFIG_REGISTER: begin
          nxt_opm = 12'(merge({20'h00000, opm_ff}, axi_req_in.wdata,
                              axi_req_in.wstrb));
        end
        pbc_pkg::ADDR_LIMIT: begin
          nxt_lim = 12'(merge({20'h00000, lim_ff}, axi_req_in.wdata,
                              axi_req_in.wstrb));
        end
        pbc_pkg::ADDR_STATUS: begin
          nxt_bresp = pbc_pkg::RESP_OKAY;
        end
        default: begin
          nxt_bresp = pbc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (cfg_rst) begin
      nxt_opm = pbc_pkg::OPERATING_CONFIG_REGISTER_RST;
      nxt_lim = pbc_pkg::LIMIT_RST;
    end
    if (rvalid_ff && axi_req_in.rready) begin
      nxt_rvalid = 1'b0;
    end
    if (axi_req_in.arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = pbc_pkg::RESP_OKAY;
      case (ra)
        pbc_pkg::ADDR_OPERATING_CONFIG_REGISTER: nxt_rdata = {20'h00000, opm_ff};
        pbc_pkg::ADDR_LIMIT: nxt_rdata = {20'h00000, lim_ff};
        pbc_pkg::ADDR_STATUS: nxt_rdata = {27'h0000000, stat};
        default: begin
          nxt_rdata = 32'h00000000;
          nxt_rresp = pbc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      opm_ff <= pbc_pkg::OPERATING_CONFIG_REGISTER_RST;
      lim_ff <= pbc_pkg::LIMIT_RST;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end else begin
      opm_ff <= nxt_opm;
      lim_ff <= nxt_lim;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  always_comb begin
    axi_rsp_out.awready = wr_go;
    axi_rsp_out.wready = wr_go;
    axi_rsp_out.bresp = bresp_ff;
    axi_rsp_out.bvalid = bvalid_ff;
    axi_rsp_out.arready = !rvalid_ff;
    axi_rsp_out.rdata = rdata_ff;
    axi_rsp_out.rresp = rresp_ff;
    axi_rsp_out.rvalid = rvalid_ff;
  end

  // Receiver core.
  pbc_pkg::pbc_mode_t mode_ff, nxt_mode;
  logic [5:0] tick_cnt_ff, nxt_tick_cnt;
  logic [2:0] xdiv_ff, nxt_xdiv;
  logic [17:0] tmr_ff, nxt_tmr;
  logic [6:0] ei_ff, nxt_ei;
  logic [4:0] cnt_ff, nxt_cnt;
  logic dem_x_ff, nxt_dem_x;
  logic out_ff, nxt_out;
  logic [7:0] out_age_ff, nxt_out_age;
  logic lrel_ff, nxt_lrel;
  logic [7:0] ci_ff, nxt_ci;
  logic clk_run_ff, nxt_clk_run;
  logic phase_ff, nxt_phase;
  logic rechk_ff, nxt_rechk;
  logic [4:0] rcnt_ff, nxt_rcnt;
  logic clk_ff, nxt_clk;
  logic [7:0] frc_low_ff, nxt_frc_low;
  logic frc_prev_ff, nxt_frc_prev;
  logic rel_pend_ff, nxt_rel_pend;
  logic [7:0] rtmr_ff, nxt_rtmr;
  logic [9:0] hlow_ff, nxt_hlow;
  logic drv_ff, nxt_drv;
  logic [3:0] drv_hist_ff, nxt_drv_hist;
  logic act_ff, nxt_act;
  logic tick, xtick, dem_edge, out_edge, is_t, is_2t, blip, err;
  logic frc_low, host_low, fail;
  logic [4:0] need;
  logic [7:0] d2lo, d2hi;
  logic [17:0] sleep_ticks;

  always_comb begin
    tick = tick_cnt_ff == pbc_pkg::TICK_LAST;
    nxt_tick_cnt = tick ? 6'h00 : 6'(tick_cnt_ff + 6'h01);
    xtick = tick
      && (xdiv_ff == pbc_pkg::pbc_xlast(opm_ff.rate_range_select));
    nxt_xdiv = !tick ? xdiv_ff : (xtick ? 3'h0 : 3'(xdiv_ff + 3'h1));
    dem_edge = xtick && (dem_st_ff != dem_x_ff);
    nxt_dem_x = xtick ? dem_st_ff : dem_x_ff;
    need = pbc_pkg::pbc_need(opm_ff.nbit);
    d2lo = pbc_pkg::pbc_dbl_lo(lim_ff);
    d2hi = pbc_pkg::pbc_dbl_hi(lim_ff);
    sleep_ticks = 18'(18'(opm_ff.sleep)
      * (opm_ff.xsleep ? 18'(pbc_pkg::SLEEP_XMULT) : 18'h00001)
      * 18'(SLEEP_UNIT));

    // Spacing and low-hold bounds keep the host's edge rate and
    // response time finite, at the cost of clipping very long lows.
    nxt_out = out_ff;
    nxt_out_age = out_age_ff;
    nxt_lrel = lrel_ff;
    out_edge = 1'b0;
    if (xtick) begin
      if (out_age_ff != 8'hFF) begin
        nxt_out_age = 8'(out_age_ff + 8'h01);
      end
      if (dem_st_ff) begin
        nxt_lrel = 1'b0;
      end
      if (!out_ff && out_age_ff >= pbc_pkg::T_DATA_LMAX_X) begin
        nxt_out = 1'b1;
        nxt_out_age = 8'h00;
        nxt_lrel = 1'b1;
        out_edge = 1'b1;
      end else if (out_ff != dem_st_ff
                   && out_age_ff >= pbc_pkg::T_DATA_MIN_X
                   && !(lrel_ff && !dem_st_ff)) begin
        nxt_out = dem_st_ff;
        nxt_out_age = 8'h00;
        out_edge = 1'b1;
      end
    end

    // Clock recovery.
    nxt_ci = (xtick && ci_ff != 8'hFF) ? 8'(ci_ff + 8'h01) : ci_ff;
    nxt_clk_run = clk_run_ff;
    nxt_phase = phase_ff;
    nxt_rechk = rechk_ff;
    nxt_rcnt = rcnt_ff;
    is_t = ci_ff >= 8'(lim_ff.lim_min) && ci_ff < 8'(lim_ff.lim_max);
    is_2t = ci_ff >= d2lo && ci_ff < d2hi;
    blip = 1'b0;
    err = 1'b0;
    if (mode_ff == pbc_pkg::MD_RECV) begin
      if (out_edge) begin
        nxt_ci = 8'h00;
        if (rechk_ff) begin
          nxt_rcnt = is_t ? 5'(rcnt_ff + 5'h01) : 5'h00;
          if (is_t && 5'(rcnt_ff + 5'h01) >= need) begin
            nxt_rechk = 1'b0;
          end
        end else if (!clk_run_ff) begin
          if (is_2t) begin
            nxt_clk_run = 1'b1;
            nxt_phase = 1'b1;
            blip = 1'b1;
          end
          // Before the start bit there is no clock to halt, so other
          // spacings, such as the idle gap before the first edge, pass.
        end else if (is_t) begin
          // The sync point is mid-bit for Manchester and bit end for
          // bi-phase, so both codes share this phase tracker.
          nxt_phase = !phase_ff;
          blip = !phase_ff;
        end else if (is_2t && phase_ff) begin
          blip = 1'b1;
        end else begin
          err = 1'b1;
        end
      end else if (clk_run_ff && ci_ff >= d2hi) begin
        err = 1'b1;
      end
      if (rechk_ff && need == 5'h00) begin
        nxt_rechk = 1'b0;
      end
      if (err) begin
        nxt_clk_run = 1'b0;
        nxt_rechk = 1'b1;
        nxt_rcnt = 5'h00;
      end
    end else begin
      nxt_clk_run = 1'b0;
      nxt_rechk = 1'b0;
      nxt_rcnt = 5'h00;
      nxt_ci = 8'h00;
    end
    nxt_clk = blip ? 1'b1 : (tick ? 1'b0 : clk_ff);

    // Force pin and host line monitoring.
    frc_low = !frc_st_ff;
    nxt_frc_prev = frc_st_ff;
    nxt_frc_low = !frc_low ? 8'h00 :
      ((tick && frc_low_ff != 8'hFF) ? 8'(frc_low_ff + 8'h01) : frc_low_ff);
    host_low = !dat_st_ff && !drv_ff && drv_hist_ff == 4'h0;
    nxt_hlow = !host_low ? 10'h000 :
      ((tick && hlow_ff != 10'h3FF) ? 10'(hlow_ff + 10'h001) : hlow_ff);
    cfg_rst = tick && host_low && hlow_ff == pbc_pkg::T_OFF_MAX_TICKS;

    // Mode sequencing.
    nxt_mode = mode_ff;
    nxt_tmr = tick ? 18'(tmr_ff + 18'h00001) : tmr_ff;
    nxt_ei = ei_ff;
    nxt_cnt = cnt_ff;
    fail = 1'b0;
    case (mode_ff)
      pbc_pkg::MD_SLEEP: begin
        if (frc_low && frc_low_ff >= pbc_pkg::T_FORCE_DLY_TICKS) begin
          nxt_mode = pbc_pkg::MD_STARTUP;
          nxt_tmr = 18'h00000;
        end else if (!frc_low && opm_ff.sleep != pbc_pkg::SLEEP_FOREVER
                     && tmr_ff >= sleep_ticks) begin
          nxt_mode = pbc_pkg::MD_STARTUP;
          nxt_tmr = 18'h00000;
        end
      end
      pbc_pkg::MD_STARTUP: begin
        nxt_ei = 7'h00;
        nxt_cnt = 5'h00;
        if (tmr_ff >= pbc_pkg::T_STARTUP_TICKS) begin
          nxt_tmr = 18'h00000;
          if (frc_low || need == 5'h00) begin
            nxt_mode = pbc_pkg::MD_RECV;
          end else begin
            nxt_mode = pbc_pkg::MD_CHECK;
          end
        end
      end
      pbc_pkg::MD_CHECK: begin
        if (xtick) begin
          nxt_ei = 7'(ei_ff + 7'h01);
        end
        if (dem_edge) begin
          if (ei_ff < 7'(lim_ff.lim_min)) begin
            fail = 1'b1;
          end else begin
            nxt_ei = 7'h00;
            nxt_cnt = 5'(cnt_ff + 5'h01);
            if (5'(cnt_ff + 5'h01) >= need) begin
              nxt_mode = pbc_pkg::MD_RECV;
            end
          end
        end else if (xtick && 7'(ei_ff + 7'h01) >= 7'(lim_ff.lim_max)) begin
          fail = 1'b1;
        end
        if (fail) begin
          nxt_mode = frc_low ? pbc_pkg::MD_STARTUP : pbc_pkg::MD_SLEEP;
          nxt_tmr = 18'h00000;
        end
      end
      pbc_pkg::MD_RECV: begin
        if (!host_low && hlow_ff >= pbc_pkg::T_OFF_MIN_TICKS) begin
          nxt_mode = pbc_pkg::MD_SYNC;
          nxt_tmr = 18'h00000;
        end
      end
      pbc_pkg::MD_SYNC: begin
        if (tmr_ff >= pbc_pkg::T_SYNC_TICKS) begin
          nxt_mode = frc_low ? pbc_pkg::MD_STARTUP : pbc_pkg::MD_SLEEP;
          nxt_tmr = 18'h00000;
        end
      end
      default: begin
        nxt_mode = pbc_pkg::MD_SLEEP;
      end
    endcase

    // Force-pin release returns the receiver to polling after a delay.
    nxt_rel_pend = rel_pend_ff;
    nxt_rtmr = (tick && rel_pend_ff) ? 8'(rtmr_ff + 8'h01) : rtmr_ff;
    if (frc_st_ff && !frc_prev_ff && mode_ff == pbc_pkg::MD_RECV
        && frc_low_ff >= pbc_pkg::T_HOLD_MIN_TICKS) begin
      nxt_rel_pend = 1'b1;
      nxt_rtmr = 8'h00;
    end else if (rel_pend_ff && rtmr_ff >= pbc_pkg::T_REL_DLY_TICKS) begin
      nxt_rel_pend = 1'b0;
      nxt_mode = pbc_pkg::MD_SLEEP;
      nxt_tmr = 18'h00000;
    end

    nxt_drv = (mode_ff == pbc_pkg::MD_RECV && !out_ff
               && !(rechk_ff && opm_ff.noise_dis))
              || mode_ff == pbc_pkg::MD_SYNC;
    nxt_drv_hist = {drv_hist_ff[2:0], drv_ff};
    nxt_act = nxt_mode != pbc_pkg::MD_SLEEP;
    stat.clk_run = clk_run_ff;
    stat.rechk = rechk_ff;
    stat.mode = mode_ff;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_ff <= pbc_pkg::MD_SLEEP;
      tick_cnt_ff <= 6'h00;
      xdiv_ff <= 3'h0;
      tmr_ff <= 18'h00000;
      ei_ff <= 7'h00;
      cnt_ff <= 5'h00;
      dem_x_ff <= 1'b1;
      out_ff <= 1'b1;
      out_age_ff <= 8'h00;
      lrel_ff <= 1'b0;
      ci_ff <= 8'h00;
      clk_run_ff <= 1'b0;
      phase_ff <= 1'b0;
      rechk_ff <= 1'b0;
      rcnt_ff <= 5'h00;
      clk_ff <= 1'b0;
      frc_low_ff <= 8'h00;
      frc_prev_ff <= 1'b1;
      rel_pend_ff <= 1'b0;
      rtmr_ff <= 8'h00;
      hlow_ff <= 10'h000;
      drv_ff <= 1'b0;
      drv_hist_ff <= 4'h0;
      act_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      tick_cnt_ff <= nxt_tick_cnt;
      xdiv_ff <= nxt_xdiv;
      tmr_ff <= nxt_tmr;
      ei_ff <= nxt_ei;
      cnt_ff <= nxt_cnt;
      dem_x_ff <= nxt_dem_x;
      out_ff <= nxt_out;
      out_age_ff <= nxt_out_age;
      lrel_ff <= nxt_lrel;
      ci_ff <= nxt_ci;
      clk_run_ff <= nxt_clk_run;
      phase_ff <= nxt_phase;
      rechk_ff <= nxt_rechk;
      rcnt_ff <= nxt_rcnt;
      clk_ff <= nxt_clk;
      frc_low_ff <= nxt_frc_low;
      frc_prev_ff <= nxt_frc_prev;
      rel_pend_ff <= nxt_rel_pend;
      rtmr_ff <= nxt_rtmr;
      hlow_ff <= nxt_hlow;
      drv_ff <= nxt_drv;
      drv_hist_ff <= nxt_drv_hist;
      act_ff <= nxt_act;
    end
  end

  // The data line is open drain: only ever pulled low.
  assign data_pin_out = 1'b0;
  assign data_pin_oe_n_out = !drv_ff;
  assign data_clk_out = clk_ff;
  assign active_indicator_out = act_ff;

endmodule

`default_nettype wire

// ===== sim/pbc_host_model.sv
// Host microcontroller model on the open-drain data line.
`timescale 1ns/1ps
`default_nettype none
module pbc_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Off command request and its low time in clock cycles
  input wire logic off_req_in,
  input wire logic [15:0] len_in,
  // Device side of the line
  input wire logic dev_oe_n_in,
  input wire logic dev_out_in,
  // Resolved line and host busy flag
  output logic line_out,
  output logic busy_out
);
  logic [15:0] cnt_ff;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) cnt_ff <= 16'h0000;
    else if (off_req_in && cnt_ff == 16'h0000) cnt_ff <= len_in;
    else if (cnt_ff != 16'h0000) cnt_ff <= cnt_ff - 16'h0001;
  end
  assign busy_out = cnt_ff != 16'h0000;
  // The pull-up wins unless either party pulls the line low.
  assign line_out = !(busy_out || (!dev_oe_n_in && !dev_out_in));
endmodule
`default_nettype wire

// ===== sim/pbc_props.sv
// Port-level assertion checker for the polled bit-check receiver.
`timescale 1ns/1ps
`default_nettype none
module pbc_props (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // Watched ports
  input wire pbc_pkg::pbc_axi_req_t axi_req_in,
  input wire pbc_pkg::pbc_axi_rsp_t axi_rsp_out,
  input wire logic data_pin_out,
  input wire logic data_pin_oe_n_out,
  input wire logic data_clk_out,
  input wire logic active_indicator_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  // Counts how long the device pulls the line, so a stuck low is caught.
  logic [15:0] low_ff;
  logic [15:0] nxt_low;
  always_comb begin
    nxt_low = data_pin_oe_n_out ? 16'h0000 : low_ff + 16'h0001;
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) low_ff <= 16'h0000;
    else low_ff <= nxt_low;
  end
  sequence wr_take;
    axi_req_in.awvalid && axi_req_in.wvalid && axi_rsp_out.awready;
  endsequence
  sequence rd_take;
    axi_req_in.arvalid && axi_rsp_out.arready;
  endsequence
  a_wr_gate: assert property (axi_rsp_out.awready == (axi_req_in.awvalid
    && axi_req_in.wvalid && !axi_rsp_out.bvalid))
    else $error("write ready wrong");
  a_rd_gate: assert property (axi_rsp_out.arready == !axi_rsp_out.rvalid)
    else $error("read ready wrong");
  a_wr_answer: assert property (wr_take |=> axi_rsp_out.bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (rd_take |=> axi_rsp_out.rvalid)
    else $error("read response missing");
  a_wr_retire: assert property (axi_rsp_out.bvalid && axi_req_in.bready
    |=> !axi_rsp_out.bvalid)
    else $error("write response not retired");
  a_open_drain: assert property (data_pin_out == 1'b0)
    else $error("data pin driven high");
  a_sleep_quiet: assert property (!active_indicator_out [*2] |->
    data_pin_oe_n_out)
    else $error("line pulled while asleep");
  a_clk_active: assert property (data_clk_out |-> active_indicator_out)
    else $error("bit clock while asleep");
  a_clk_short: assert property ($rose(data_clk_out) |->
    ##[1:52] !data_clk_out)
    else $error("bit clock strobe too long");
  a_low_bound: assert property (low_ff < 16'h9920)
    else $error("line held low too long");
endmodule
bind pbc_receiver pbc_props u_props (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out),
  .data_pin_out(data_pin_out), .data_pin_oe_n_out(data_pin_oe_n_out),
  .data_clk_out(data_clk_out), .active_indicator_out(active_indicator_out));
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the polled bit-check receiver.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TK = 51;
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  pbc_pkg::pbc_axi_req_t req = '0;
  pbc_pkg::pbc_axi_rsp_t rsp;
  logic dem = 1'b1;
  logic force_n = 1'b1;
  logic off_req = 1'b0;
  logic [15:0] off_len = 16'h07F8;
  logic line, pin_out, oe_n, dclk, act, busy;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_clk = 0;
  int n_sync = 0;
  always #20 mclk_in = ~mclk_in;
  always @(posedge dclk) n_clk++;
  always @(negedge oe_n) n_sync++;
  pbc_receiver #(.SLEEP_UNIT(4)) uut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .axi_req_in(req), .axi_rsp_out(rsp), .dem_in(dem), .data_pin_in(line),
    .data_pin_out(pin_out), .data_pin_oe_n_out(oe_n), .force_n_in(force_n),
    .data_clk_out(dclk), .active_indicator_out(act));
  pbc_host_model host (.clk_in(mclk_in), .rstn_in(rstn_in),
    .off_req_in(off_req), .len_in(off_len), .dev_oe_n_in(oe_n),
    .dev_out_in(pin_out), .line_out(line), .busy_out(busy));
  task automatic step();
    @(posedge mclk_in);
    #1;
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) step();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One AXI transfer; valid and payload hold until ready is seen.
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
    @(posedge mclk_in);
    req.awaddr <= a;
    req.araddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= w;
    req.wvalid <= w;
    req.arvalid <= !w;
    req.bready <= w;
    req.rready <= !w;
    // Handshakes are read at the edge itself, before that edge takes effect.
    do @(posedge mclk_in);
    while ((w ? rsp.awready : rsp.arready) !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    req.arvalid <= 1'b0;
    do @(posedge mclk_in);
    while ((w ? rsp.bvalid : rsp.rvalid) !== 1'b1);
    q = rsp.rdata;
    r = w ? rsp.bresp : rsp.rresp;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 32'h0, q, r);
    chk(q, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic wrchk(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
    chk(32'(r), 32'(er));
  endtask
  // Rate range 3, twelve check bits, permanent sleep, squelch on.
  task automatic t_regs();
    rdchk(8'h00, 32'h000008C4, 2'h0);
    rdchk(8'h04, 32'h0000060E, 2'h0);
    rdchk(8'h0C, 32'h00000000, 2'h2);
    wrchk(8'h0C, 32'hFFFFFFFF, 2'h2);
    wrchk(8'h08, 32'hFFFFFFFF, 2'h0);
    wrchk(8'h00, 32'h00000BEB, 2'h0);
    wrchk(8'h04, 32'h000005CE, 2'h0);
    rdchk(8'h00, 32'h00000BEB, 2'h0);
  endtask
  task automatic t_sleep();
    ticks(200);
    chk(32'(act), 32'h0);
    rdchk(8'h08, 32'h0, 2'h0);
  endtask
  // Forced wake, then a 2T start bit must start the recovered clock.
  task automatic t_recv();
    int c0;
    force_n <= 1'b0;
    ticks(6);
    chk(32'(act), 32'h0);
    ticks(6);
    chk(32'(act), 32'h1);
    ticks(140);
    rdchk(8'h08, 32'h3, 2'h0);
    c0 = n_clk;
    dem <= 1'b0;
    ticks(9);
    chk(32'(line), 32'h0);
    ticks(9);
    dem <= 1'b1;
    ticks(18);
    chk(32'(n_clk - c0), 32'h0);
    dem <= 1'b0;
    ticks(36);
    dem <= 1'b1;
    ticks(18);
    dem <= 1'b0;
    ticks(18);
    dem <= 1'b1;
    ticks(36);
    chk(32'(n_clk != c0), 32'h1);
    dem <= 1'b0;
    ticks(2);
    dem <= 1'b1;
    ticks(2);
    chk(32'(line), 32'h0);
    ticks(10);
    rdchk(8'h08, 32'h0000000B, 2'h0);
    dem <= 1'b0;
    ticks(9);
    chk(32'(line), 32'h1);
    dem <= 1'b1;
    ticks(9);
  endtask
  // Off command, long low on the demodulator, then release of force.
  task automatic t_off();
    int c0;
    int n;
    logic [31:0] q;
    logic [1:0] r;
    c0 = n_sync;
    off_req <= 1'b1;
    step();
    off_req <= 1'b0;
    for (n = 0; n < 3000 && busy; n++) step();
    chk(32'(busy), 32'h0);
    ticks(10);
    chk(32'(n_sync - c0), 32'h1);
    ticks(150);
    dem <= 1'b0;
    ticks(110);
    chk(32'(line), 32'h1);
    dem <= 1'b1;
    bus(1'b0, 8'h08, 32'h0, q, r);
    chk(32'(q[4]), 32'h0);
    ticks(150);
    force_n <= 1'b1;
    ticks(6);
    chk(32'(act), 32'h1);
    ticks(8);
    chk(32'(act), 32'h0);
  endtask
  // A low just past the off window's upper end restores both words.
  task automatic t_cfg();
    int n;
    off_len <= 16'h6798;
    off_req <= 1'b1;
    step();
    off_req <= 1'b0;
    for (n = 0; n < 27000 && busy; n++) step();
    chk(32'(busy), 32'h0);
    rdchk(8'h00, 32'h000008C4, 2'h0);
    rdchk(8'h04, 32'h0000060E, 2'h0);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_sleep();
    t_recv();
    t_off();
    t_cfg();
    complete_run();
  end
  initial begin
    repeat (95000) @(posedge mclk_in);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
